// ---- hw/spi_eeprom_slave_front_end.v ----
`timescale 1ns/100ps
`include "spi_eeprom_front_regs.vh"

module spi_eeprom_slave_front_end (
  // Clock and reset
  input wire sys_clk_i,
  input wire reset_n_i,
  // Serial pins
  input wire sclk_i,
  input wire cs_n_i,
  input wire sdi_i,
  input wire pause_n_i,
  input wire guard_n_i,
  output reg sdo_o,
  output reg sdo_oe_o,
  // Status path to the core
  input wire busy_i,
  input wire [7:0] status_in_i,
  output reg [7:0] status_o,
  output reg status_program_o,
  // Decoded frame events
  output reg [2:0] opcode_o,
  output reg opcode_valid_o,
  output reg opcode_error_o,
  output reg [7:0] rx_byte_o,
  output reg rx_byte_valid_o,
  output reg write_permit_o,
  // Transmit data for array reads
  input wire [7:0] tx_data_i
);

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  reg [4:0] sync_a;
  reg [4:0] sync_b;
  reg sclk_d;
  reg cs_n_d;
  reg guard_n_d;
  wire sclk_s = sync_b[0];
  wire cs_n_s = sync_b[1];
  wire sdi_s = sync_b[2];
  wire pause_n_s = sync_b[3];
  wire guard_n_s = sync_b[4];

  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_a <= 5'h1E;
      sync_b <= 5'h1E;
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
      guard_n_d <= 1'b1;
    end else begin
      sync_a <= {guard_n_i, pause_n_i, sdi_i, cs_n_i, sclk_i};
      sync_b <= sync_a;
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
      guard_n_d <= guard_n_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d;
  wire cs_fall = ~cs_n_s & cs_n_d;
  wire cs_rise = cs_n_s & ~cs_n_d;
  wire guard_fall = ~guard_n_s & guard_n_d;

  // --------------------------------------------------------------------
  // Frame state
  // --------------------------------------------------------------------
  localparam ST_IDLE = 4'b0001;
  localparam ST_OPCODE = 4'b0010;
  localparam ST_DATA = 4'b0100;
  localparam ST_REJECT = 4'b1000;

  reg [3:0] state;
  reg [3:0] next_state;
  reg paused;
  reg [2:0] bit_cnt;
  reg [7:0] shift_in;
  reg [7:0] shift_out;
  reg [2:0] op;
  reg status_cancel;
  reg first_out;

  wire [7:0] rx_full = {shift_in[6:0], sdi_s};
  wire guard_blocks = ~guard_n_s & status_o[`STAT_GUARD_PIN_ENABLE];
  wire op_known = (rx_full[7:4] == `OP_UPPER_NIBBLE) && (rx_full[2:0] != 3'h0)
    && (rx_full[2:0] != 3'h7);
  // Shift engine runs only when selected, active and not paused
  wire active = ~cs_n_s & ~paused & (state == ST_OPCODE || state == ST_DATA);
  wire byte_done = active & sclk_rise & (bit_cnt == 3'h7);
  wire [7:0] status_read_val = busy_i ? 8'hFF : status_o;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cs_fall) begin
          next_state = ST_OPCODE;
        end
      end
      ST_OPCODE: begin
        if (byte_done) begin
          next_state = op_known ? ST_DATA : ST_REJECT;
        end
      end
      ST_DATA: begin
        next_state = ST_DATA;
      end
      ST_REJECT: begin
        next_state = ST_REJECT;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (cs_n_s) begin
      next_state = ST_IDLE;
    end
  end

  // --------------------------------------------------------------------
  // Frame events
  // --------------------------------------------------------------------
  wire opcode_end = byte_done & (state == ST_OPCODE);
  wire data_end = byte_done & (state == ST_DATA);
  wire read_op = (op == `OP_STATUS_READ) || (op == `OP_DATA_READ);
  wire status_read_start = opcode_end & op_known & (rx_full[2:0] == `OP_STATUS_READ);
  // Status write lands only with permit, no guard block or cancel, core idle
  wire status_accept = data_end & (op == `OP_STATUS_WRITE) & write_permit_o & ~guard_blocks
    & ~status_cancel & ~busy_i;

  // --------------------------------------------------------------------
  // Frame counters
  // --------------------------------------------------------------------
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shift_in <= 8'h00;
    end else begin
      state <= next_state;
      if (cs_n_s || cs_fall) begin
        bit_cnt <= 3'h0;
        shift_in <= 8'h00;
      end else if (active && sclk_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        shift_in <= rx_full;
      end
    end
  end

  // --------------------------------------------------------------------
  // Pause tracking
  // --------------------------------------------------------------------
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      paused <= 1'b0;
    end else begin
      // Pause changes state only while the serial clock is low or on deselect
      if (cs_n_s) begin
        paused <= 1'b0;
      end else if (!sclk_s) begin
        paused <= ~pause_n_s;
      end
    end
  end

  // --------------------------------------------------------------------
  // Guard cancel
  // --------------------------------------------------------------------
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_cancel <= 1'b0;
    end else begin
      // A guard fall wins over the frame-start clear
      if (~cs_n_s && guard_fall && status_o[`STAT_GUARD_PIN_ENABLE]) begin
        status_cancel <= 1'b1;
      end else if (cs_n_s || cs_fall) begin
        status_cancel <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Opcode decode and write permit
  // --------------------------------------------------------------------
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op <= 3'h0;
      opcode_o <= 3'h0;
      opcode_valid_o <= 1'b0;
      opcode_error_o <= 1'b0;
      rx_byte_o <= 8'h00;
      rx_byte_valid_o <= 1'b0;
      write_permit_o <= 1'b0;
    end else begin
      opcode_valid_o <= 1'b0;
      opcode_error_o <= 1'b0;
      rx_byte_valid_o <= 1'b0;
      if (opcode_end) begin
        op <= rx_full[2:0];
        if (op_known) begin
          opcode_o <= rx_full[2:0];
          opcode_valid_o <= 1'b1;
          if (rx_full[2:0] == `OP_SET_WRITE_PERMIT) begin
            write_permit_o <= 1'b1;
          end
          if (rx_full[2:0] == `OP_CLEAR_WRITE_PERMIT) begin
            write_permit_o <= 1'b0;
          end
        end else begin
          opcode_error_o <= 1'b1;
        end
      end
      if (data_end) begin
        rx_byte_o <= rx_full;
        rx_byte_valid_o <= 1'b1;
      end
      // An accepted status write uses up the permit
      if (status_accept) begin
        write_permit_o <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Status register
  // --------------------------------------------------------------------
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_o <= `STAT_RESET;
      status_program_o <= 1'b0;
    end else begin
      status_program_o <= 1'b0;
      // Core copy is followed only while no programming cycle runs
      if (!busy_i) begin
        status_o[7:2] <= status_in_i[7:2] & 6'h23;
      end
      status_o[`STAT_BUSY] <= busy_i;
      status_o[`STAT_WRITE_PERMIT] <= write_permit_o;
      // Only the guard enable and block protect bits are programmable
      if (status_accept) begin
        status_o[`STAT_GUARD_PIN_ENABLE] <= rx_full[`STAT_GUARD_PIN_ENABLE];
        status_o[3:2] <= rx_full[3:2];
        status_program_o <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Serial output
  // --------------------------------------------------------------------
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_out <= 8'h00;
      first_out <= 1'b0;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      if (cs_n_s || cs_fall) begin
        first_out <= 1'b0;
      end else if (status_read_start) begin
        shift_out <= status_read_val;
        first_out <= 1'b1;
      end else if (data_end) begin
        if (op == `OP_STATUS_READ) begin
          shift_out <= status_read_val;
        end else if (op == `OP_DATA_READ) begin
          shift_out <= tx_data_i;
        end
        first_out <= read_op;
      end
      // Line follows the bit counter while the clock is low, so the
      // current bit comes back at once after a pause ends
      if (!active || state != ST_DATA || !first_out) begin
        sdo_oe_o <= 1'b0;
      end else if (!sclk_s) begin
        sdo_oe_o <= 1'b1;
        sdo_o <= shift_out[~bit_cnt];
      end
    end
  end

endmodule // spi_eeprom_slave_front_end

// ---- hw/spi_eeprom_front_regs.vh ----
`ifndef SPI_EEPROM_FRONT_REGS_VH
`define SPI_EEPROM_FRONT_REGS_VH
// Opcode decode: upper nibble zero, bit 3 ignored, low three bits select
`define OP_UPPER_NIBBLE 4'h0
`define OP_SET_WRITE_PERMIT 3'h6
`define OP_CLEAR_WRITE_PERMIT 3'h4
`define OP_STATUS_READ 3'h5
`define OP_STATUS_WRITE 3'h1
`define OP_DATA_READ 3'h3
`define OP_DATA_WRITE 3'h2
// Status register fields
`define STAT_GUARD_PIN_ENABLE 7
`define STAT_WRITE_PERMIT 1
`define STAT_BUSY 0
`define STAT_RESET 8'h00
`define STAT_WRITABLE_MASK 8'h8C
`endif

// ---- verif/spi_front_props.sv ----
`timescale 1ns/100ps
module spi_front_props (
  // Watched ports
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire cs_n_i,
  input wire pause_n_i,
  input wire guard_n_i,
  input wire sdo_oe_o,
  input wire [7:0] status_o,
  input wire status_program_o,
  input wire opcode_valid_o,
  input wire opcode_error_o,
  input wire write_permit_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_DESEL_OE: assert property (cs_n_i [*4] |-> !sdo_oe_o) else $error("oe deselected");
  AST_PAUSE_OE: assert property (!pause_n_i [*5] |-> !sdo_oe_o) else $error("oe paused");
  AST_ERR_OE: assert property (opcode_error_o |=> !sdo_oe_o [*3]) else $error("oe bad op");
  AST_OP_ONCE: assert property (opcode_valid_o |=> !opcode_valid_o && !opcode_error_o)
    else $error("second opcode pulse");
  AST_GUARD: assert property ((!guard_n_i && status_o[7]) [*5] |=> !status_program_o)
    else $error("write while guarded");
  AST_PERMIT: assert property (status_program_o |-> $past(write_permit_o))
    else $error("write without permit");
  AST_CLEAR: assert property (status_program_o |-> ##[0:2] !write_permit_o)
    else $error("permit kept");
  AST_MASK: assert property (status_program_o |-> status_o[6:4] == 3'h0)
    else $error("reserved bits set");
  AST_RESET: assert property ($rose(reset_n_i) |-> !write_permit_o && !sdo_oe_o)
    else $error("reset state");
  cover property (opcode_error_o);
  cover property (status_program_o);
  cover property (!pause_n_i && !cs_n_i);
endmodule // spi_front_props

bind spi_eeprom_slave_front_end spi_front_props u_props (.*);

// ---- verif/spi_master_model.sv ----
`timescale 1ns/100ps
module spi_master_model (
  // Serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  output logic pause_n_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  // Pulled-up line while the slave has released it
  wire so = sdo_oe_i ? sdo_i : 1'b1;
  initial {sclk_o, cs_n_o, sdi_o, pause_n_o} = 4'h5;
  task automatic sel(input logic s);
    cs_n_o = !s;
    #200;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi_o = tx[i];
      #80 sclk_o = 1;
      rx[i] = so;
      #80 sclk_o = 0;
    end
  endtask
  task automatic hold(input logic p);
    pause_n_o = !p;
    #200;
  endtask
endmodule // spi_master_model

// ---- verif/test_spi_eeprom_slave_front_end.sv ----
`timescale 1ns/100ps
module test_spi_eeprom_slave_front_end;
  logic sys_clk_i = 0;
  logic reset_n_i = 0;
  logic guard_n_i = 1;
  logic busy_i = 0;
  logic [7:0] rd;
  logic [7:0] tx_data = 8'h00;
  wire sclk, cs_n, sdi, pause_n, sdo, sdo_oe, prog, op_e, op_v, rx_v, permit;
  wire [7:0] status;
  wire [7:0] rx_b;
  wire [2:0] opcode;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n_err = 0;
  int n_ok = 0;
  int n_rx = 0;
  int n_prog = 0;
  spi_eeprom_slave_front_end dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .sdi_i(sdi), .pause_n_i(pause_n), .guard_n_i(guard_n_i), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .busy_i(busy_i), .status_in_i(status & 8'h8C), .status_o(status),
    .status_program_o(prog), .opcode_o(opcode), .opcode_valid_o(op_v), .opcode_error_o(op_e),
    .rx_byte_o(rx_b), .rx_byte_valid_o(rx_v), .write_permit_o(permit), .tx_data_i(tx_data));
  spi_master_model m (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .pause_n_o(pause_n),
    .sdo_i(sdo), .sdo_oe_i(sdo_oe));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    n_err += op_e;
    n_ok += op_v;
    n_rx += rx_v;
    n_prog += prog;
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] b, input bit two);
    m.sel(1);
    m.xfer(a, rd);
    if (two) m.xfer(b, rd);
    m.sel(0);
  endtask
  task automatic t_permit();
    check(permit, 0);
    frame(8'h0E, 0, 0);
    check({opcode, permit}, {3'h6, 1'b1});
    frame(8'h04, 0, 0);
    check(permit, 0);
  endtask
  task automatic t_bad();
    logic [7:0] ops [3] = '{8'h11, 8'h07, 8'h08};
    foreach (ops[i]) begin
      n_err = 0;
      n_ok = 0;
      frame(8'h06, 0, 0);
      frame(ops[i], 8'h8C, 1);
      check({n_err[0], status & 8'h8C}, {1'b1, 8'h00});
      check(n_ok, 1);
    end
  endtask
  task automatic t_write();
    logic [7:0] d [5] = '{8'h8C, 8'h00, 8'h00, 8'h04, 8'h88};
    logic [7:0] e [5] = '{8'h8C, 8'h8C, 8'h8C, 8'h04, 8'h88};
    logic [1:0] g [5] = '{2'b11, 2'b00, 2'b10, 2'b11, 2'b00};
    logic [7:0] p [5] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h01};
    foreach (d[i]) begin
      guard_n_i = g[i][1];
      frame(8'h06, 0, 0);
      n_prog = 0;
      m.sel(1);
      m.xfer(8'h01, rd);
      guard_n_i = g[i][0];
      m.xfer(d[i], rd);
      m.sel(0);
      check(status & 8'h8C, e[i]);
      check(rx_b, d[i]);
      check(n_prog, p[i]);
    end
    guard_n_i = 1;
  endtask
  task automatic t_read();
    frame(8'h06, 0, 0);
    m.sel(1);
    m.xfer(8'h05, rd);
    m.hold(1);
    check(sdo_oe, 0);
    m.xfer(8'hFF, rd);
    m.hold(0);
    m.xfer(8'h00, rd);
    m.sel(0);
    check(rd, 8'h8A);
    busy_i = 1;
    frame(8'h05, 0, 1);
    check(rd, 8'hFF);
    busy_i = 0;
  endtask
  task automatic t_data();
    tx_data = 8'h5A;
    n_rx = 0;
    m.sel(1);
    m.xfer(8'h03, rd);
    m.xfer(8'h00, rd);
    m.xfer(8'h00, rd);
    m.sel(0);
    check(rd, 8'h5A);
    check(n_rx, 2);
    tx_data = 8'h00;
  endtask
  initial begin
    #64 reset_n_i = 1;
    #24;
    t_permit();
    t_bad();
    t_write();
    t_read();
    t_data();
    end_of_test();
  end
endmodule // test_spi_eeprom_slave_front_end
